// File: common/p9pms_regs.svh
// Register offsets, field positions and reset values of the port 9 upper pin selector.
// Assumes byte-wide registers addressed by their byte offsets on a 10-bit address.
`ifndef P9PMS_REGS_SVH
`define P9PMS_REGS_SVH

`define P9PMS_ADDR_W 10
`define P9PMS_DATA_W 8

// Register offsets
`define P9PMS_OFS_TMR_B4_MODE 10'h035C
`define P9PMS_OFS_SER4_CTRL 10'h0366
`define P9PMS_OFS_ADC_CTRL1 10'h03D7
`define P9PMS_OFS_DAC_CTRL 10'h03DC
`define P9PMS_OFS_P9_DATA 10'h03F1
`define P9PMS_OFS_P9_DIR 10'h03F3
`define P9PMS_OFS_PULLUP_CTRL 10'h03FE

// Field positions
`define P9PMS_BIT_TMR_EVT_CLK 7
`define P9PMS_BIT_SER4_SYNC_CLK 6
`define P9PMS_BIT_SER4_PORT_SEL 3
`define P9PMS_BIT_SER4_TX_DIS 2
`define P9PMS_BIT_ADC_OPAMP_HI 7
`define P9PMS_BIT_ADC_OPAMP_LO 6
`define P9PMS_BIT_DAC1_EN 1
`define P9PMS_BIT_PU_P94_97 3
`define P9PMS_BIT_PIN4 4
`define P9PMS_BIT_PIN5 5
`define P9PMS_BIT_PIN6 6

// Reset values
`define P9PMS_RST_TMR_B4_MODE 8'h00
`define P9PMS_RST_SER4_CTRL 8'h00
`define P9PMS_RST_ADC_CTRL1 8'h00
`define P9PMS_RST_DAC_CTRL 8'h00
`define P9PMS_RST_P9_DATA 8'h00
`define P9PMS_RST_P9_DIR 8'h00
`define P9PMS_RST_PULLUP_CTRL 8'h00

`endif

// File: common/p9pms_pkg.sv
// Types shared by the port 9 upper pin selector.
// Assumes p9pms_regs.svh supplies the numeric constants.
package p9pms_pkg;

  // Function that a pin is currently giving to the outside
  typedef enum logic [2:0] {
    P9PMS_PORT_IN = 3'b000,
    P9PMS_PORT_IN_PU = 3'b001,
    P9PMS_PORT_OUT = 3'b011,
    P9PMS_PERIPH_OUT = 3'b010,
    P9PMS_PERIPH_IN = 3'b110,
    P9PMS_ANALOG = 3'b111
  } p9pms_mode_t;

  // Op-amp connection field encodings
  typedef enum logic [1:0] {
    P9PMS_OPAMP_OFF = 2'b00,
    P9PMS_OPAMP_EXTEND_A = 2'b01,
    P9PMS_OPAMP_EXTEND_B = 2'b10,
    P9PMS_OPAMP_OUT = 2'b11
  } p9pms_opamp_t;

endpackage

// File: design/p9pms_sync.sv
// Three-stage input synchroniser with agreement filter for pad inputs.
// Assumes inputs are asynchronous to clk; output changes only when stages two and three agree.
`timescale 1ns/100ps
module p9pms_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      meta_r <= async_in;
      stage2_r <= meta_r;
      stage3_r <= stage2_r;
    end
  end

  // Per-bit filter: a new level counts only once two settled stages agree
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          sync_out[gi] <= 1'b0;
        end else if (stage2_r[gi] == stage3_r[gi]) begin
          sync_out[gi] <= stage3_r[gi];
        end
      end
    end
  endgenerate

endmodule

// File: design/p9pms_top.sv
// Pin function selector for port 9 pins 6, 5 and 4, with its control registers.
// Assumes a simple byte register port and pad cells that resolve out/oe/pull-up outside.
//
// Summary of operation
// - Direction 0, pull-up 0, no peripheral select: plain port input without pull-up.
// - Direction 0 with shared pull-up set gives pulled-up input; direction 1 is port output.
// - Serial unit 4 port select with op-amp bits 00: transmit data on pin 6 unless disabled; pin 5 drives its clock if sync-clock is set, else takes it in.
// - Op-amp bits: 10 pin 6 analog in, 01 pin 5 analog in, 11 pin 5 op-amp out.
// - D-A enable drives channel 1 on pin 4; as plain port input with event-clock bit clear, pin 4 feeds timer count source.
`timescale 1ns/100ps
`include "p9pms_regs.svh"
module p9pms_top
  import p9pms_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [`P9PMS_ADDR_W-1:0] reg_addr,
  input wire logic [`P9PMS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`P9PMS_DATA_W-1:0] reg_rdata,
  // Pads: pin 6, 5, 4 in bits 2, 1, 0
  input wire logic [2:0] pad_in,
  output logic [2:0] pad_out,
  output logic [2:0] pad_oe,
  output logic [2:0] pad_pullup_en,
  // Analog switches
  output logic analog_extend_in_b,
  output logic analog_extend_in_a,
  output logic opamp_out_en,
  output logic dac_ch1_out,
  // Serial unit 4
  input wire logic serial4_tx_out,
  input wire logic serial4_clock_signal,
  output logic serial4_clock_in,
  // Timer B channel 4
  output logic timer_b_ch4_count_in
);

  localparam int P6 = 2;
  localparam int P5 = 1;
  localparam int P4 = 0;

  logic [7:0] tmr_b4_mode_r;
  logic [7:0] ser4_ctrl_r;
  logic [7:0] adc_ctrl1_r;
  logic [7:0] dac_ctrl_r;
  logic [7:0] p9_data_r;
  logic [7:0] p9_dir_r;
  logic [7:0] pullup_ctrl_r;
  logic [7:0] rdata_nxt;
  logic [2:0] pin_sync;
  logic [2:0] dir3;
  logic pu_shared;
  p9pms_opamp_t opamp;
  p9pms_mode_t mode6;
  p9pms_mode_t mode5;
  p9pms_mode_t mode4;
  logic [2:0] out_nxt;
  logic [2:0] oe_nxt;
  logic [2:0] pu_nxt;
  logic ser4_sel;

  // Register writes; unmapped addresses are ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmr_b4_mode_r <= `P9PMS_RST_TMR_B4_MODE;
      ser4_ctrl_r <= `P9PMS_RST_SER4_CTRL;
      adc_ctrl1_r <= `P9PMS_RST_ADC_CTRL1;
      dac_ctrl_r <= `P9PMS_RST_DAC_CTRL;
      p9_data_r <= `P9PMS_RST_P9_DATA;
      p9_dir_r <= `P9PMS_RST_P9_DIR;
      pullup_ctrl_r <= `P9PMS_RST_PULLUP_CTRL;
    end else if (reg_wr) begin
      case (reg_addr)
        `P9PMS_OFS_TMR_B4_MODE: tmr_b4_mode_r <= reg_wdata;
        `P9PMS_OFS_SER4_CTRL: ser4_ctrl_r <= reg_wdata;
        `P9PMS_OFS_ADC_CTRL1: adc_ctrl1_r <= reg_wdata;
        `P9PMS_OFS_DAC_CTRL: dac_ctrl_r <= reg_wdata;
        `P9PMS_OFS_P9_DATA: p9_data_r <= reg_wdata;
        `P9PMS_OFS_P9_DIR: p9_dir_r <= reg_wdata;
        `P9PMS_OFS_PULLUP_CTRL: pullup_ctrl_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read mux; the data register shows live pin levels for the three handled pins
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `P9PMS_OFS_TMR_B4_MODE: rdata_nxt = tmr_b4_mode_r;
      `P9PMS_OFS_SER4_CTRL: rdata_nxt = ser4_ctrl_r;
      `P9PMS_OFS_ADC_CTRL1: rdata_nxt = adc_ctrl1_r;
      `P9PMS_OFS_DAC_CTRL: rdata_nxt = dac_ctrl_r;
      `P9PMS_OFS_P9_DATA: begin
        rdata_nxt = p9_data_r;
        rdata_nxt[`P9PMS_BIT_PIN6:`P9PMS_BIT_PIN4] = pin_sync;
      end
      `P9PMS_OFS_P9_DIR: rdata_nxt = p9_dir_r;
      `P9PMS_OFS_PULLUP_CTRL: rdata_nxt = pullup_ctrl_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Pad inputs come from outside the clock domain
  p9pms_sync #(
    .WIDTH(3)
  ) p9pms_sync_inst (
    .clk(clk),
    .rstn(rstn),
    .async_in(pad_in),
    .sync_out(pin_sync)
  );

  assign dir3 = p9_dir_r[`P9PMS_BIT_PIN6:`P9PMS_BIT_PIN4];
  assign pu_shared = pullup_ctrl_r[`P9PMS_BIT_PU_P94_97];
  assign opamp = p9pms_opamp_t'({adc_ctrl1_r[`P9PMS_BIT_ADC_OPAMP_HI], adc_ctrl1_r[`P9PMS_BIT_ADC_OPAMP_LO]});
  assign ser4_sel = ser4_ctrl_r[`P9PMS_BIT_SER4_PORT_SEL];

  // Port function shared by every pin when no peripheral owns it
  function automatic p9pms_mode_t port_mode(input logic dir, input logic pu);
    if (dir) begin
      port_mode = P9PMS_PORT_OUT;
    end else if (pu) begin
      port_mode = P9PMS_PORT_IN_PU;
    end else begin
      port_mode = P9PMS_PORT_IN;
    end
  endfunction

  // Pin 6: analog input wins, then serial transmit, then port
  always_comb begin
    if (opamp == P9PMS_OPAMP_EXTEND_B) begin
      mode6 = P9PMS_ANALOG;
    end else if (opamp == P9PMS_OPAMP_OFF && ser4_sel) begin
      // Transmit disabled leaves the pin undriven rather than falling back to port
      mode6 = ser4_ctrl_r[`P9PMS_BIT_SER4_TX_DIS] ? P9PMS_PERIPH_IN : P9PMS_PERIPH_OUT;
    end else begin
      mode6 = port_mode(dir3[P6], pu_shared);
    end
  end

  // Pin 5: op-amp analog modes, then serial clock, then port
  always_comb begin
    if (opamp == P9PMS_OPAMP_EXTEND_A || opamp == P9PMS_OPAMP_OUT) begin
      mode5 = P9PMS_ANALOG;
    end else if (opamp == P9PMS_OPAMP_OFF && ser4_sel) begin
      mode5 = ser4_ctrl_r[`P9PMS_BIT_SER4_SYNC_CLK] ? P9PMS_PERIPH_OUT : P9PMS_PERIPH_IN;
    end else begin
      mode5 = port_mode(dir3[P5], pu_shared);
    end
  end

  // Pin 4: D-A output wins over port; timer input rides on port input
  always_comb begin
    if (dac_ctrl_r[`P9PMS_BIT_DAC1_EN]) begin
      mode4 = P9PMS_ANALOG;
    end else begin
      mode4 = port_mode(dir3[P4], pu_shared);
    end
  end

  // Pad drive values from each pin's mode
  always_comb begin
    out_nxt[P6] = (mode6 == P9PMS_PERIPH_OUT) ? serial4_tx_out : p9_data_r[`P9PMS_BIT_PIN6];
    out_nxt[P5] = (mode5 == P9PMS_PERIPH_OUT) ? serial4_clock_signal : p9_data_r[`P9PMS_BIT_PIN5];
    out_nxt[P4] = p9_data_r[`P9PMS_BIT_PIN4];
    oe_nxt[P6] = (mode6 == P9PMS_PORT_OUT) || (mode6 == P9PMS_PERIPH_OUT);
    oe_nxt[P5] = (mode5 == P9PMS_PORT_OUT) || (mode5 == P9PMS_PERIPH_OUT);
    oe_nxt[P4] = (mode4 == P9PMS_PORT_OUT);
    pu_nxt[P6] = (mode6 == P9PMS_PORT_IN_PU);
    pu_nxt[P5] = (mode5 == P9PMS_PORT_IN_PU);
    pu_nxt[P4] = (mode4 == P9PMS_PORT_IN_PU);
  end

  // Pad controls are registered so a mode change never glitches the pad
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pad_out <= 3'h0;
      pad_oe <= 3'h0;
      pad_pullup_en <= 3'h0;
    end else begin
      pad_out <= out_nxt;
      pad_oe <= oe_nxt;
      pad_pullup_en <= pu_nxt;
    end
  end

  // Analog switch selects and peripheral-facing inputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      analog_extend_in_b <= 1'b0;
      analog_extend_in_a <= 1'b0;
      opamp_out_en <= 1'b0;
      dac_ch1_out <= 1'b0;
      serial4_clock_in <= 1'b0;
      timer_b_ch4_count_in <= 1'b0;
    end else begin
      analog_extend_in_b <= (opamp == P9PMS_OPAMP_EXTEND_B);
      analog_extend_in_a <= (opamp == P9PMS_OPAMP_EXTEND_A);
      opamp_out_en <= (opamp == P9PMS_OPAMP_OUT);
      dac_ch1_out <= (mode4 == P9PMS_ANALOG);
      // Only an external clock is fed back; an internal clock would loop onto itself
      serial4_clock_in <= (mode5 == P9PMS_PERIPH_IN) & pin_sync[P5];
      // Count source only while direction, pull-up, event-clock and D-A bits are all clear
      timer_b_ch4_count_in <= (mode4 == P9PMS_PORT_IN) & ~tmr_b4_mode_r[`P9PMS_BIT_TMR_EVT_CLK]
        & pin_sync[P4];
    end
  end

endmodule

// File: verif/p9pms_top_assertions.sv
// Checker for the port 9 upper pin selector, watching the top module's ports only.
// Assumes register writes land on their strobe edge and pin controls follow one edge later.
`timescale 1ns/100ps
`include "p9pms_regs.svh"
module p9pms_top_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`P9PMS_ADDR_W-1:0] reg_addr,
  input wire logic [`P9PMS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [2:0] pad_out,
  input wire logic [2:0] pad_oe,
  input wire logic [2:0] pad_pullup_en,
  input wire logic analog_extend_in_b,
  input wire logic analog_extend_in_a,
  input wire logic opamp_out_en,
  input wire logic dac_ch1_out,
  input wire logic serial4_tx_out,
  input wire logic timer_b_ch4_count_in
);
  logic [7:0] d, p, s, a, c, t;
  logic gate;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Shadow registers let the checker predict each pin without seeing the bodies
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {d, p, s, a, c, t} <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `P9PMS_OFS_P9_DIR: d <= reg_wdata;
        `P9PMS_OFS_PULLUP_CTRL: p <= reg_wdata;
        `P9PMS_OFS_SER4_CTRL: s <= reg_wdata;
        `P9PMS_OFS_ADC_CTRL1: a <= reg_wdata;
        `P9PMS_OFS_DAC_CTRL: c <= reg_wdata;
        `P9PMS_OFS_TMR_B4_MODE: t <= reg_wdata;
        default: ;
      endcase
    end
  end
  // Any of these bits takes pin 4 away from the timer
  assign gate = d[4] | p[3] | c[1] | t[7];
  idle_input_a: assert property ($past({d[6], p[3], s[3], a[7:6]} == 5'h0) |-> !pad_oe[2] && !pad_pullup_en[2])
    else $error("pin 6 not a plain input");
  pullup_in_a: assert property ($past(!d[5] && p[3] && !s[3] && a[7:6] == 2'b00) |-> pad_pullup_en[1] && !pad_oe[1])
    else $error("pin 5 pull-up missing");
  port_out_a: assert property ($past(d[4] && !c[1]) |-> pad_oe[0] && !pad_pullup_en[0])
    else $error("pin 4 not a port output");
  serial_tx_a: assert property ($past(s[3] && !s[2] && a[7:6] == 2'b00) |-> pad_oe[2] && pad_out[2] == $past(serial4_tx_out))
    else $error("pin 6 not carrying serial data");
  opamp_sel_a: assert property ({analog_extend_in_b, analog_extend_in_a, opamp_out_en} == {$past(a[7:6]) == 2'b10,
    $past(a[7:6]) == 2'b01, $past(a[7:6]) == 2'b11})
    else $error("op-amp routing wrong");
  dac_route_a: assert property (dac_ch1_out == $past(c[1]) && (!$past(c[1]) || !pad_oe[0]))
    else $error("pin 4 analog output wrong");
  sclk_in_a: assert property ($past(s[3] && !s[6] && a[7:6] == 2'b00) |-> !pad_oe[1])
    else $error("pin 5 driven in clock input mode");
  timer_gate_a: assert property (gate && $past(gate) && $past(gate, 2) |-> !timer_b_ch4_count_in)
    else $error("timer input not gated");
endmodule
bind p9pms_top p9pms_top_assertions p9pms_top_assertions_inst (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
  .analog_extend_in_b(analog_extend_in_b), .analog_extend_in_a(analog_extend_in_a),
  .opamp_out_en(opamp_out_en), .dac_ch1_out(dac_ch1_out), .serial4_tx_out(serial4_tx_out),
  .timer_b_ch4_count_in(timer_b_ch4_count_in)
);

// File: verif/p9pms_pin_model.sv
// Outside world of pins 6, 5 and 4: resolves each pad wire and feeds it back.
// Assumes pins 5 and 4 have an outside driver; pin 6 floats when nobody drives it.
`timescale 1ns/100ps
module p9pms_pin_model (
  input wire logic clk,
  input wire logic [2:0] pad_out,
  input wire logic [2:0] pad_oe,
  input wire logic [2:0] pad_pullup_en,
  input wire logic [2:0] ext_val,
  output logic [2:0] pad_in
);
  logic wander_r = 1'b0;
  // A floating pin keeps changing, so no stale level can pass for a real one
  always @(posedge clk) wander_r <= ~wander_r;
  // Device drive first, then pull-up, then the outside level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : pad_pullup_en[i] ? 1'b1 : (i == 2) ? wander_r : ext_val[i];
    end
  end
endmodule

// File: verif/test_port9_upper_pin_function_select.sv
// Self-checking bench for the port 9 upper pin selector: random and corner pin setups.
// Assumes the pin model closes the pads and the checker is bound to the top module.
`timescale 1ns/100ps
`include "p9pms_regs.svh"
module test_port9_upper_pin_function_select;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [`P9PMS_ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_v = 1'b0;
  logic sck_v = 1'b0;
  logic [2:0] ext_val = '0;
  logic [7:0] reg_rdata;
  logic [2:0] pad_in, pad_out, pad_oe, pad_pullup_en;
  logic anb, ana, opo, dac1, sck_in, tmr_in;
  logic [7:0] v [7];
  logic [8:0] e;
  logic [2:0] lvl;
  logic [9:0] ofs [7] = '{`P9PMS_OFS_P9_DIR, `P9PMS_OFS_PULLUP_CTRL, `P9PMS_OFS_SER4_CTRL,
    `P9PMS_OFS_ADC_CTRL1, `P9PMS_OFS_DAC_CTRL, `P9PMS_OFS_TMR_B4_MODE, `P9PMS_OFS_P9_DATA};
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h7e32_705a;
  p9pms_top p9pms_top_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en), .analog_extend_in_b(anb), .analog_extend_in_a(ana),
    .opamp_out_en(opo), .dac_ch1_out(dac1), .serial4_tx_out(tx_v), .serial4_clock_signal(sck_v),
    .serial4_clock_in(sck_in), .timer_b_ch4_count_in(tmr_in));
  p9pms_pin_model p9pms_pin_model_inst (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .ext_val(ext_val), .pad_in(pad_in));
  // Clock and a hang guard sized well above the roughly 1900 cycles of the run
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  // Expected {oe, pull-up, driven value}: port function, then peripherals override
  function automatic logic [8:0] exp_pins(input logic [7:0] d, p, s, a, c, q);
    logic [2:0] oe, pu, o;
    oe = {d[6], d[5], d[4]};
    pu = ~oe & {3{p[3]}};
    o = {q[6], q[5], q[4]} & oe;
    if (a[7:6] == 2'b00 && s[3]) {oe[2], pu[2], o[2]} = {~s[2], 1'b0, ~s[2] & tx_v};
    if (a[7:6] == 2'b00 && s[3]) {oe[1], pu[1], o[1]} = {s[6], 1'b0, s[6] & sck_v};
    if (a[7:6] == 2'b10) {oe[2], pu[2], o[2]} = 3'b000;
    if (a[6]) {oe[1], pu[1], o[1]} = 3'b000;
    if (c[1]) {oe[0], pu[0], o[0]} = 3'b000;
    return {oe, pu, o};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] ad, input logic [7:0] val);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= val;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe, so it is taken there
  task automatic rd(input logic [9:0] ad, input logic [7:0] exp, input logic [7:0] mask = 8'hff);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata & mask, exp & mask);
  endtask
  task automatic test_done();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Reset values, an unmapped read, then random setups with op-amp versus serial corners first
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 6; k++) rd(ofs[k], 8'h00);
    rd(10'h0100, 8'h00);
    check({pad_oe, pad_pullup_en}, 6'h00);
    $display("reset test done");
    for (int i = 0; i < 48; i++) begin
      foreach (v[k]) v[k] = 8'($random(seed));
      if (i < 4) begin
        v[2] = 8'h08;
        v[3] = {i[1:0], 6'h00};
      end
      tx_v <= 1'($random(seed));
      sck_v <= 1'($random(seed));
      ext_val <= 3'($random(seed));
      foreach (v[k]) wr(ofs[k], v[k]);
      repeat (10) @(posedge clk);
      #1;
      check({pad_oe, pad_pullup_en, pad_out & pad_oe}, exp_pins(v[0], v[1], v[2], v[3], v[4], v[6]));
      check({anb, ana, opo, dac1}, {v[3][7:6] == 2'b10, v[3][7:6] == 2'b01, v[3][7:6] == 2'b11, v[4][1]});
      check(tmr_in, !(v[0][4] | v[1][3] | v[4][1] | v[5][7]) & ext_val[0]);
      check(sck_in, (v[3][7:6] == 2'b00 && v[2][3] && !v[2][6]) & ext_val[1]);
      for (int k = 0; k < 6; k++) rd(ofs[k], v[k]);
      // Data register shows settled pin levels; a floating pin 6 has no defined level, so it is masked
      e = exp_pins(v[0], v[1], v[2], v[3], v[4], v[6]);
      lvl = e[2:0] | e[5:3] | (~e[8:6] & ~e[5:3] & ext_val);
      rd(`P9PMS_OFS_P9_DATA, {v[6][7], lvl, v[6][3:0]}, {1'b1, e[8] | e[5], 6'h3f});
    end
    $display("random test done");
    test_done();
  end
endmodule
